//--- include/timer16_regs.vh
// register map, fields, reset values and timing counts of the 16-bit timer
`ifndef TIMER16_REGS_VH
`define TIMER16_REGS_VH
// ****************************************
// register byte addresses
// ****************************************
`define ADDR_CONTROL_ONE 8'h00
`define ADDR_CONTROL_TWO 8'h04
`define ADDR_STATUS 8'h08
`define ADDR_CAP1_HIGH 8'h0c
`define ADDR_CAP1_LOW 8'h10
`define ADDR_CAP2_HIGH 8'h14
`define ADDR_CAP2_LOW 8'h18
`define ADDR_COUNT_HIGH 8'h1c
`define ADDR_COUNT_LOW 8'h20
`define ADDR_ALT_HIGH 8'h24
`define ADDR_ALT_LOW 8'h28
// ****************************************
// control one fields
// ****************************************
`define C1_CAPTURE_IRQ_ENABLE 7
`define C1_CAPTURE_EDGE_TWO 1
`define C1_OVERFLOW_IRQ_ENABLE 5
// ****************************************
// control two fields
// ****************************************
`define C2_EXTERNAL_EDGE 0
`define C2_CLOCK_SEL_LO 2
`define C2_CLOCK_SEL_HI 3
`define C2_PWM_MODE 4
`define C2_ONE_PULSE_MODE 5
`define C2_CAPTURE_EDGE_ONE 6
// ****************************************
// status fields
// ****************************************
`define ST_CAPTURE_FLAG_ONE 7
`define ST_CAPTURE_FLAG_TWO 4
`define ST_OVERFLOW_FLAG 5
// ****************************************
// values
// ****************************************
`define COUNT_RESET 16'hfffc
`define COUNT_TOP 16'hffff
`define CLOCK_SEL_DIV2 2'h0
`define CLOCK_SEL_DIV4 2'h1
`define CLOCK_SEL_DIV8 2'h2
`define CLOCK_SEL_EXT 2'h3
`define EXT_GAP_EDGES 4
`endif

//--- verilog/edge_catch.v
// synchronous edge detector for one external input
`timescale 1ns/1ps
module edge_catch (
  input wire clock,
  input wire rst_b,
  input wire enable,
  input wire pin,
  input wire rising,
  output reg hit
);
  reg last;
  reg primed;
  // ****************************************
  // compare with previous sample
  // ****************************************
  always @(posedge clock) begin
    if (!rst_b) begin
      last <= 1'b0;
      primed <= 1'b0;
      hit <= 1'b0;
    end else if (enable) begin
      last <= pin;
      primed <= 1'b1;
      hit <= primed & (rising ? (pin & ~last) : (~pin & last));
    end
  end
endmodule // edge_catch

//--- verilog/timer16_counter_capture.v
// 16-bit free-running timer with coherent reads, overflow flag and two captures
// Contract
// R01 - 16-bit free-running up-counter readable through primary and alternate views
// R02 - writing primary counter or alternate low byte loads fffc
// R03 - reset loads fffc; fffc is the only reload value
// R04 - counts at clock divided by 2, 4, 8 or external edges
// R05 - external clock used only when both clock select bits are one
// R06 - external edge select picks rising or falling external edges
// R07 - external edges are synchronised to the internal clock before counting
// R08 - external clock keeps four internal clock edges between active edges
// R09 - high byte read latches low byte until low byte is read
// R10 - lone low byte read returns live low byte
// R11 - rollover from ffff to 0000 sets overflow flag
// R12 - overflow request when flag, enable set and global mask clear
// R13 - overflow flag clears by status read then primary low access
// R14 - alternate low byte accesses never clear the overflow flag
// R15 - counter runs in wait, freezes in halt, resumes held count
// R16 - each capture channel copies count on its selected input edge
// R17 - capture sets flag; shared enable and mask gate the request
// R18 - capture flag clears by status read then its low byte access
// R19 - capture high byte read blocks capture until low byte read
// R20 - capture register holds most recent capture count
// R21 - in one-pulse or pwm mode only channel two captures
// R22 - capture inputs always connected; any qualifying edge captures
// R23 - non-external clock select codes give division 2, 4, 8
//
// Our own choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "timer16_regs.vh"
module timer16_counter_capture (
  input wire clock,
  input wire rst_b,
  input wire clock_enable,
  input wire halt_mode,
  input wire global_irq_mask,
  input wire external_timer_clock_pin,
  input wire capture_input_pin_one,
  input wire capture_input_pin_two,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  output reg timer_irq
);
  // ****************************************
  // state
  // ****************************************
  reg [15:0] count;
  reg [7:0] timer_control_one;
  reg [7:0] timer_control_two;
  reg overflow_flag;
  reg [1:0] capture_flag;
  reg [15:0] capture_value_one;
  reg [15:0] capture_value_two;
  reg [1:0] capture_blocked;
  reg [7:0] low_latch;
  reg low_latched;
  reg [2:0] prescale;
  reg ovf_armed;
  reg [1:0] cap_armed;
  reg [7:0] aw_addr;
  reg aw_held;
  reg w_held;
  reg [7:0] w_data;
  reg w_strobe;
  wire ext_hit;
  wire [1:0] cap_hit;
  wire [1:0] clock_select_bits;
  wire run;
  wire tick;
  wire do_write;
  wire do_read;
  wire [7:0] wr_addr;
  reg [7:0] next_rdata;
  reg next_rerr;
  reg next_werr;
  wire ovf_set;
  wire ovf_clear_hit;
  wire [1:0] cap_clear_hit;
  wire cap_one_allowed;
  wire [1:0] cap_take;
  wire ovf_request;
  wire cap_request;
  assign clock_select_bits = timer_control_two[`C2_CLOCK_SEL_HI:`C2_CLOCK_SEL_LO];
  assign run = clock_enable & ~halt_mode; // R15
  assign do_write = aw_held & w_held & ~s_axi_bvalid;
  assign do_read = s_axi_arvalid & s_axi_arready;
  assign wr_addr = aw_addr;
  // ****************************************
  // external clock and capture edges
  // ****************************************
  edge_catch ext_edge (
    .clock(clock),
    .rst_b(rst_b),
    .enable(run),
    .pin(external_timer_clock_pin),
    .rising(timer_control_two[`C2_EXTERNAL_EDGE]),
    .hit(ext_hit)
  ); // R06 R07 R08
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : cap
      edge_catch cap_edge (
        .clock(clock),
        .rst_b(rst_b),
        .enable(clock_enable),
        .pin(gi == 0 ? capture_input_pin_one : capture_input_pin_two),
        .rising(gi == 0 ? timer_control_two[`C2_CAPTURE_EDGE_ONE] : timer_control_one[`C1_CAPTURE_EDGE_TWO]),
        .hit(cap_hit[gi])
      ); // R16 R22
    end
  endgenerate
  // ****************************************
  // prescaler tick
  // ****************************************
  assign tick = (clock_select_bits == `CLOCK_SEL_EXT) ? ext_hit : // R05
    (clock_select_bits == `CLOCK_SEL_DIV2) ? (prescale[0] == 1'b1) : // R23
    (clock_select_bits == `CLOCK_SEL_DIV4) ? (prescale[1:0] == 2'h3) : (prescale == 3'h7); // R04
  // ****************************************
  // flag events
  // ****************************************
  assign ovf_set = run & tick & (count == `COUNT_TOP); // R11
  assign ovf_clear_hit = (do_read & (s_axi_araddr == `ADDR_COUNT_LOW)) |
    (do_write & (wr_addr == `ADDR_COUNT_LOW)); // R13 R14
  assign cap_clear_hit[0] = (do_read & (s_axi_araddr == `ADDR_CAP1_LOW)) |
    (do_write & (wr_addr == `ADDR_CAP1_LOW)); // R18
  assign cap_clear_hit[1] = (do_read & (s_axi_araddr == `ADDR_CAP2_LOW)) |
    (do_write & (wr_addr == `ADDR_CAP2_LOW)); // R18
  assign cap_one_allowed = ~timer_control_two[`C2_ONE_PULSE_MODE] & ~timer_control_two[`C2_PWM_MODE]; // R21
  assign cap_take[0] = cap_hit[0] & ~capture_blocked[0] & cap_one_allowed; // R19
  assign cap_take[1] = cap_hit[1] & ~capture_blocked[1]; // R19 R22
  assign ovf_request = overflow_flag & timer_control_one[`C1_OVERFLOW_IRQ_ENABLE]; // R12
  assign cap_request = (|capture_flag) & timer_control_one[`C1_CAPTURE_IRQ_ENABLE]; // R17
  // ****************************************
  // read data mux
  // ****************************************
  always @* begin
    next_rdata = 8'h00;
    next_rerr = 1'b0;
    case (s_axi_araddr)
      `ADDR_CONTROL_ONE: next_rdata = timer_control_one;
      `ADDR_CONTROL_TWO: next_rdata = timer_control_two;
      `ADDR_STATUS: begin
        next_rdata[`ST_CAPTURE_FLAG_ONE] = capture_flag[0];
        next_rdata[`ST_CAPTURE_FLAG_TWO] = capture_flag[1];
        next_rdata[`ST_OVERFLOW_FLAG] = overflow_flag;
      end
      `ADDR_CAP1_HIGH: next_rdata = capture_value_one[15:8];
      `ADDR_CAP1_LOW: next_rdata = capture_value_one[7:0];
      `ADDR_CAP2_HIGH: next_rdata = capture_value_two[15:8];
      `ADDR_CAP2_LOW: next_rdata = capture_value_two[7:0];
      `ADDR_COUNT_HIGH, `ADDR_ALT_HIGH: next_rdata = count[15:8]; // R01
      `ADDR_COUNT_LOW, `ADDR_ALT_LOW: next_rdata = low_latched ? low_latch : count[7:0]; // R09 R10
      default: next_rerr = 1'b1;
    endcase
  end
  always @* begin
    case (wr_addr)
      `ADDR_CONTROL_ONE, `ADDR_CONTROL_TWO, `ADDR_STATUS, `ADDR_CAP1_HIGH, `ADDR_CAP1_LOW,
      `ADDR_CAP2_HIGH, `ADDR_CAP2_LOW, `ADDR_COUNT_HIGH, `ADDR_COUNT_LOW, `ADDR_ALT_HIGH,
      `ADDR_ALT_LOW: next_werr = 1'b0;
      default: next_werr = 1'b1;
    endcase
  end
  // ****************************************
  // bus handshakes
  // ****************************************
  always @(posedge clock) begin
    if (!rst_b) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 8'h00;
      w_strobe <= 1'b0;
    end else if (clock_enable) begin
      s_axi_awready <= ~aw_held & ~s_axi_awready & s_axi_awvalid;
      if (s_axi_awvalid & s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      s_axi_wready <= ~w_held & ~s_axi_wready & s_axi_wvalid;
      if (s_axi_wvalid & s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata[7:0];
        w_strobe <= s_axi_wstrb[0];
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= next_werr ? 2'h2 : 2'h0;
        aw_held <= 1'b0;
        w_held <= 1'b0;
      end else if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  // ****************************************
  // bus handshakes, read side
  // ****************************************
  always @(posedge clock) begin
    if (!rst_b) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'h0;
    end else if (clock_enable) begin
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
      if (do_read) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h000000, next_rdata};
        s_axi_rresp <= next_rerr ? 2'h2 : 2'h0;
      end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
  // ****************************************
  // control registers
  // ****************************************
  always @(posedge clock) begin
    if (!rst_b) begin
      timer_control_one <= 8'h00;
      timer_control_two <= 8'h00;
    end else if (clock_enable && do_write && w_strobe) begin
      if (wr_addr == `ADDR_CONTROL_ONE) begin
        timer_control_one <= w_data;
      end
      if (wr_addr == `ADDR_CONTROL_TWO) begin
        timer_control_two <= w_data;
      end
    end
  end
  // ****************************************
  // capture registers
  // ****************************************
  always @(posedge clock) begin
    if (!rst_b) begin
      capture_value_one <= 16'h0000;
      capture_value_two <= 16'h0000;
    end else if (clock_enable) begin
      if (cap_take[0]) begin
        capture_value_one <= count; // R16 R20
      end
      if (cap_take[1]) begin
        capture_value_two <= count; // R16 R20
      end
    end
  end
  // ****************************************
  // interrupt request
  // ****************************************
  always @(posedge clock) begin
    if (!rst_b) begin
      timer_irq <= 1'b0;
    end else if (clock_enable) begin
      timer_irq <= ~global_irq_mask & (ovf_request | cap_request); // R12 R17
    end
  end
  // ****************************************
  // counter, flags
  // ****************************************
  always @(posedge clock) begin
    if (!rst_b) begin
      count <= `COUNT_RESET; // R03
      prescale <= 3'h0;
      overflow_flag <= 1'b0;
      capture_flag <= 2'h0;
      capture_blocked <= 2'h0;
      low_latch <= 8'h00;
      low_latched <= 1'b0;
      ovf_armed <= 1'b0;
      cap_armed <= 2'h0;
    end else if (clock_enable) begin
      if (run) begin
        prescale <= prescale + 3'h1;
        if (tick) begin
          count <= count + 16'h0001; // R01
        end
      end
      // reads: latch, arming and clearing
      if (do_read) begin
        case (s_axi_araddr)
          `ADDR_STATUS: begin
            ovf_armed <= overflow_flag;
            cap_armed <= capture_flag;
          end
          `ADDR_COUNT_HIGH, `ADDR_ALT_HIGH: begin
            if (!low_latched) begin
              low_latch <= count[7:0]; // R09
              low_latched <= 1'b1;
            end
          end
          `ADDR_COUNT_LOW, `ADDR_ALT_LOW: low_latched <= 1'b0; // R10
          `ADDR_CAP1_HIGH: capture_blocked[0] <= 1'b1; // R19
          `ADDR_CAP2_HIGH: capture_blocked[1] <= 1'b1; // R19
          `ADDR_CAP1_LOW: capture_blocked[0] <= 1'b0;
          `ADDR_CAP2_LOW: capture_blocked[1] <= 1'b0;
          default: low_latched <= low_latched;
        endcase
      end
      // writes
      if (do_write & w_strobe) begin
        if (wr_addr == `ADDR_COUNT_HIGH || wr_addr == `ADDR_COUNT_LOW || wr_addr == `ADDR_ALT_LOW) begin
          count <= `COUNT_RESET; // R02
          prescale <= 3'h0;
        end
      end
      // overflow flag: clear sequence, set wins
      if (ovf_clear_hit & ovf_armed) begin
        overflow_flag <= 1'b0; // R13 R14
        ovf_armed <= 1'b0;
      end
      if (ovf_set) begin
        overflow_flag <= 1'b1; // R11
      end
      // capture channel one
      if (cap_clear_hit[0] & cap_armed[0]) begin
        capture_flag[0] <= 1'b0; // R18
        cap_armed[0] <= 1'b0;
      end
      if (cap_take[0]) begin
        capture_flag[0] <= 1'b1; // R17
      end
      // capture channel two
      if (cap_clear_hit[1] & cap_armed[1]) begin
        capture_flag[1] <= 1'b0; // R18
        cap_armed[1] <= 1'b0;
      end
      if (cap_take[1]) begin
        capture_flag[1] <= 1'b1; // R17
      end
    end
  end
endmodule // timer16_counter_capture

//--- bench/timer16_properties.sv
// checker of bus and interrupt timing at the timer ports
`timescale 1ns/1ps
module timer16_properties (
  input wire clock,
  input wire rst_b,
  input wire clock_enable,
  input wire global_irq_mask,
  input wire timer_irq,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_bvalid,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [31:0] s_axi_rdata
);
  // ****
  // properties
  // ****
  default clocking @(posedge clock);
  endclocking
  default disable iff (!rst_b);
  AST_IRQ_MASKED: assert property (clock_enable && global_irq_mask |=> !timer_irq) else $error("irq masked");
  AST_IRQ_CAUSE: assert property ($rose(timer_irq) |-> !$past(global_irq_mask)) else $error("irq cause");
  AST_READ_ANSWER: assert property (s_axi_arvalid && s_axi_arready && clock_enable |=> s_axi_rvalid)
    else $error("read answer");
  AST_READ_BYTE: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000) else $error("read byte");
  AST_READ_DONE: assert property (clock_enable && s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read done");
  AST_ONE_READ: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("one read");
  AST_AR_PULSE: assert property (clock_enable && s_axi_arready |=> !s_axi_arready) else $error("ar pulse");
  AST_WRITE_ANSWER: assert property (s_axi_awvalid && s_axi_awready |-> ##[1:3] s_axi_bvalid)
    else $error("write answer");
  cover property ($rose(timer_irq));
  cover property (s_axi_rvalid && s_axi_rready);
  cover property (s_axi_bvalid);
endmodule // timer16_properties

//--- bench/timer16_pins.sv
// model of the outside pins: external clock and capture inputs
`timescale 1ns/1ps
module timer16_pins (
  output reg ext_clk,
  output reg cap_one,
  output reg cap_two,
  input wire clock
);
  initial begin
    ext_clk = 1'b0;
    cap_one = 1'b0;
    cap_two = 1'b0;
  end
  // n pulses then a final rise
  task automatic ext_burst(input int n);
    repeat (n) begin
      ext_clk <= 1'b1;
      repeat (4) @(posedge clock);
      ext_clk <= 1'b0;
      repeat (4) @(posedge clock);
    end
    ext_clk <= 1'b1;
    repeat (6) @(posedge clock);
  endtask
  task automatic cap_drive(input bit ch, input bit lvl);
    if (ch) cap_two <= lvl;
    else cap_one <= lvl;
    repeat (6) @(posedge clock);
  endtask
endmodule // timer16_pins

//--- bench/tb.sv
// self-checking bench of the 16-bit timer
`timescale 1ns/1ps
`include "timer16_regs.vh"
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin fails++; \
  $display("wrong value %s exp %h got %h", n, e, s); end end
module tb;
  reg clock = 1'b0;
  reg rst_b = 1'b0;
  reg clock_enable = 1'b1;
  reg halt_mode = 1'b1;
  reg irq_mask = 1'b1;
  reg [7:0] awaddr = 8'h00;
  reg awvalid = 1'b0;
  reg [31:0] wdata = 32'h0;
  reg [3:0] wstrb = 4'hf;
  reg wvalid = 1'b0;
  reg bready = 1'b0;
  reg [7:0] araddr = 8'h00;
  reg arvalid = 1'b0;
  reg rready = 1'b0;
  wire awready, wready, bvalid, arready, rvalid, timer_irq, ext_clk, cap_one, cap_two;
  wire [1:0] bresp;
  wire [1:0] rresp;
  wire [31:0] rdata;
  reg [31:0] d;
  reg [1:0] resp;
  reg [15:0] v;
  int fails = 0;
  int checks_done = 0;
  int cyc = 0;
  int seed = 30561;
  int i, n, fb;
  bit e, r, r1, r2;
  always #2 clock = ~clock;
  timer16_pins pins (.clock(clock), .ext_clk(ext_clk), .cap_one(cap_one), .cap_two(cap_two));
  timer16_counter_capture dut (.clock(clock), .rst_b(rst_b), .clock_enable(clock_enable), .halt_mode(halt_mode),
    .global_irq_mask(irq_mask), .external_timer_clock_pin(ext_clk), .capture_input_pin_one(cap_one),
    .capture_input_pin_two(cap_two), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .timer_irq(timer_irq));
  // ****
  // expectations and bus tasks
  // ****
  function automatic [7:0] c1(input bit ci, input bit oi, input bit e2);
    c1 = 8'h00;
    c1[`C1_CAPTURE_IRQ_ENABLE] = ci;
    c1[`C1_OVERFLOW_IRQ_ENABLE] = oi;
    c1[`C1_CAPTURE_EDGE_TWO] = e2;
  endfunction
  function automatic [7:0] c2(input [1:0] cs, input bit ee, input bit e1, input bit one_pulse_mode);
    c2 = 8'h00;
    c2[`C2_CLOCK_SEL_HI:`C2_CLOCK_SEL_LO] = cs;
    c2[`C2_EXTERNAL_EDGE] = ee;
    c2[`C2_CAPTURE_EDGE_ONE] = e1;
    c2[`C2_ONE_PULSE_MODE] = one_pulse_mode;
  endfunction
  function automatic [15:0] ext_exp(input int k, input bit ee);
    ext_exp = `COUNT_RESET + k[15:0] + {15'h0, ee};
  endfunction
  task automatic wr(input [7:0] a, input [7:0] x);
    bit ap, wp, dn;
    ap = 1;
    wp = 1;
    dn = 0;
    awaddr <= a;
    wdata <= {24'h0, x};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!dn) begin
      @(posedge clock);
      if (ap && awready) begin ap = 0; awvalid <= 1'b0; end
      if (wp && wready) begin wp = 0; wvalid <= 1'b0; end
      if (bvalid) begin dn = 1; resp = bresp; bready <= 1'b0; end
    end
    @(posedge clock);
  endtask
  task automatic rd(input [7:0] a);
    bit ap, dn;
    ap = 1;
    dn = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!dn) begin
      @(posedge clock);
      if (ap && arready) begin ap = 0; arvalid <= 1'b0; end
      if (rvalid) begin dn = 1; d = rdata; resp = rresp; rready <= 1'b0; end
    end
    @(posedge clock);
  endtask
  task automatic rc(input [7:0] a, input [7:0] x, input string nm);
    rd(a);
    `CHK(nm, x, d[7:0])
  endtask
  task automatic rs(input int b, input bit x, input string nm);
    rd(`ADDR_STATUS);
    `CHK(nm, x, d[b])
  endtask
  // high byte then low byte
  task automatic rv(input [7:0] hi);
    rd(hi);
    v[15:8] = d[7:0];
    rd(hi + 8'h04);
    v[7:0] = d[7:0];
  endtask
  task automatic finish_test;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      finish_test;
    end
  end
  // ****
  // scenarios
  // ****
  initial begin
    repeat (20) @(posedge clock);
    rst_b <= 1'b1;
    @(posedge clock);
    rv(`ADDR_COUNT_HIGH);
    `CHK("reset count", `COUNT_RESET, v)
    rd(8'h3c);
    `CHK("rresp", 2'h2, resp)
    wr(8'h3c, 8'h00);
    `CHK("bresp", 2'h2, resp)
    for (i = 0; i < 3; i++) begin
      wr(`ADDR_CONTROL_TWO, c2(i[1:0], 0, 0, 0));
      wr(`ADDR_ALT_LOW, 8'h00);
      halt_mode <= 1'b0;
      repeat (64) @(posedge clock);
      halt_mode <= 1'b1;
      rv(`ADDR_COUNT_HIGH);
      v = v - `COUNT_RESET;
      `CHK("ticks", 1'b1, v + 1 >= (32 >> i) && v <= (32 >> i) + 1)
    end
    wr(`ADDR_CONTROL_TWO, c2(`CLOCK_SEL_DIV2, 0, 0, 0));
    wr(`ADDR_COUNT_LOW, 8'h00);
    rc(`ADDR_COUNT_HIGH, 8'hff, "hi");
    halt_mode <= 1'b0;
    repeat (40) @(posedge clock);
    halt_mode <= 1'b1;
    rc(`ADDR_COUNT_HIGH, 8'h00, "hi again");
    rc(`ADDR_COUNT_LOW, 8'hfc, "latched lo");
    rd(`ADDR_ALT_LOW);
    v[7:0] = d[7:0];
    `CHK("live lo", 1'b1, v[7:0] > 8'h08 && v[7:0] < 8'h20)
    repeat (30) @(posedge clock);
    rc(`ADDR_ALT_LOW, v[7:0], "halted lo");
    wr(`ADDR_CONTROL_ONE, c1(0, 1, 0));
    repeat (3) @(posedge clock);
    `CHK("irq masked", 1'b0, timer_irq)
    irq_mask <= 1'b0;
    repeat (3) @(posedge clock);
    `CHK("irq", 1'b1, timer_irq)
    rs(`ST_OVERFLOW_FLAG, 1'b1, "ovf");
    rd(`ADDR_ALT_LOW);
    rs(`ST_OVERFLOW_FLAG, 1'b1, "ovf kept");
    rd(`ADDR_COUNT_LOW);
    rs(`ST_OVERFLOW_FLAG, 1'b0, "ovf clr");
    `CHK("irq clr", 1'b0, timer_irq)
    r1 = $random(seed);
    r2 = $random(seed);
    wr(`ADDR_CONTROL_TWO, c2(`CLOCK_SEL_DIV2, 0, r1, 0));
    wr(`ADDR_CONTROL_ONE, c1(1, 0, r2));
    wr(`ADDR_ALT_LOW, 8'h00);
    for (i = 0; i < 2; i++) begin
      r = i ? r2 : r1;
      fb = i ? `ST_CAPTURE_FLAG_TWO : `ST_CAPTURE_FLAG_ONE;
      pins.cap_drive(i[0], !r);
      pins.cap_drive(i[0], r);
      `CHK("cap irq", 1'b1, timer_irq)
      rs(fb, 1'b1, "cap flag");
      rv(i ? `ADDR_CAP2_HIGH : `ADDR_CAP1_HIGH);
      `CHK("cap value", `COUNT_RESET, v)
      rs(fb, 1'b0, "cap clr");
      rd(i ? `ADDR_CAP2_HIGH : `ADDR_CAP1_HIGH);
      pins.cap_drive(i[0], !r);
      pins.cap_drive(i[0], r);
      rs(fb, 1'b0, "cap blocked");
      rd(i ? `ADDR_CAP2_LOW : `ADDR_CAP1_LOW);
    end
    wstrb <= 4'h0;
    wr(`ADDR_CONTROL_ONE, 8'h00);
    wstrb <= 4'hf;
    rc(`ADDR_CONTROL_ONE, c1(1, 0, r2), "strobe off");
    wr(`ADDR_CONTROL_TWO, c2(`CLOCK_SEL_DIV2, 0, r1, 1));
    pins.cap_drive(0, !r1);
    pins.cap_drive(0, r1);
    rs(`ST_CAPTURE_FLAG_ONE, 1'b0, "one pulse cap");
    wr(`ADDR_CONTROL_TWO, c2(`CLOCK_SEL_DIV2, 0, r1, 0) | (8'h01 << `C2_PWM_MODE));
    pins.cap_drive(0, !r1);
    pins.cap_drive(0, r1);
    pins.cap_drive(1, !r2);
    pins.cap_drive(1, r2);
    rs(`ST_CAPTURE_FLAG_ONE, 1'b0, "pwm cap one");
    rs(`ST_CAPTURE_FLAG_TWO, 1'b1, "pwm cap two");
    e = $random(seed);
    n = 3 + ($random(seed) & 3);
    wr(`ADDR_CONTROL_TWO, c2(`CLOCK_SEL_EXT, e, 0, 0));
    wr(`ADDR_ALT_LOW, 8'h00);
    halt_mode <= 1'b0;
    pins.ext_burst(n);
    rv(`ADDR_COUNT_HIGH);
    `CHK("ext count", ext_exp(n, e), v)
    rs(`ST_OVERFLOW_FLAG, (n + e) >= 4, "ext ovf");
    finish_test;
  end
endmodule // tb
bind timer16_counter_capture timer16_properties chk (.clock(clock), .rst_b(rst_b), .clock_enable(clock_enable),
  .global_irq_mask(global_irq_mask), .timer_irq(timer_irq), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata));
